/* File: rtl/gtm_defs.svh */
/*
 timer interrupt clear and interval load: offsets, field positions, reset values.
 assumes a 32-bit classic wishbone bus with byte addressing.
*/
`ifndef GTM_DEFS_SVH
`define GTM_DEFS_SVH

// register byte offsets
`define GTM_OFF_RIS      8'h1C
`define GTM_OFF_MIS      8'h20
`define GTM_OFF_ICR      8'h24
`define GTM_OFF_TAILR    8'h28
`define GTM_OFF_TBILR    8'h2C
`define GTM_OFF_CFG      8'h00
`define GTM_OFF_IMR      8'h18
`define GTM_OFF_TAVAL    8'h40
`define GTM_OFF_TBVAL    8'h44

// event bit positions
`define GTM_BIT_A_TO     0
`define GTM_BIT_A_CM     1
`define GTM_BIT_A_CE     2
`define GTM_BIT_RTC      3
`define GTM_BIT_B_TO     8
`define GTM_BIT_B_CM     9
`define GTM_BIT_B_CE     10
`define GTM_EVT_MASK     32'h0000070F

// load value fields
`define GTM_HALF_W       16
`define GTM_HALF_ONES    16'hFFFF
`define GTM_HALF_ZERO    16'h0000
`define GTM_WORD_ZERO    32'h00000000

// width config: values below 3'h4 select a 32-bit mode
`define GTM_CFG_W        3
`define GTM_CFG_16BIT    3'h4
`define GTM_CFG_RESET    3'h0

`endif

/* File: rtl/gtm_pkg.sv */
/*
 types shared by the timer interrupt and load block.
 assumes nothing beyond the defines header.
*/
package gtm_pkg;

    typedef logic [31:0] gtm_word_t;
    typedef logic [15:0] gtm_half_t;

    typedef enum logic [1:0] {
        GTM_BUS_IDLE = 2'b01,
        GTM_BUS_ACK  = 2'b10
    } gtm_bus_st_t;

endpackage : gtm_pkg

/* File: rtl/gtm_sticky_bit.sv */
/*
 one sticky interrupt status bit: set by an event, cleared by a write of one.
 assumes event and clear are synchronous single-cycle strobes.
*/
`timescale 1ns/1ps

module gtm_sticky_bit (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // event and clear
    input  wire logic set_i,
    input  wire logic clr_i,
    // status
    output logic      raw_o
);

    typedef struct packed {
        logic raw;
    } gtm_sticky_t;

    gtm_sticky_t s_q;
    gtm_sticky_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.raw = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (set_i) begin
            s_d.raw = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign raw_o = s_q.raw;

endmodule : gtm_sticky_bit

/* File: rtl/gtm_load_reg.sv */
/*
 one 16-bit interval load half with a write strobe and a selectable reset value.
 assumes the reset value is steady while reset is held.
*/
`timescale 1ns/1ps

module gtm_load_reg (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire gtm_pkg::gtm_half_t rst_val_i,
    // write
    input  wire logic              we_i,
    input  wire gtm_pkg::gtm_half_t wdata_i,
    // value
    output gtm_pkg::gtm_half_t     val_o
);

    typedef struct packed {
        gtm_pkg::gtm_half_t val;
    } gtm_load_t;

    gtm_load_t s_q;
    gtm_load_t s_d;

    always_comb begin
        s_d = s_q;
        if (we_i) begin
            s_d.val = wdata_i;
        end
    end

    // synchronous reset: the reset value is a mode-chosen constant
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.val <= rst_val_i;
        end else begin
            s_q <= s_d;
        end
    end

    assign val_o = s_q.val;

endmodule : gtm_load_reg

/* File: rtl/gtm_timer_irq_load.sv */
/*
 timer interrupt status with write-one clear, mask and interrupt output, plus
 timer a / timer b interval load registers with 32-bit aliasing.
 assumes a classic wishbone master, events as one-cycle strobes, one clock.
*/
`include "gtm_defs.svh"
`timescale 1ns/1ps

module gtm_timer_irq_load (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // timer events, one-cycle strobes
    input  wire logic        evt_a_timeout_i,
    input  wire logic        evt_a_capture_match_i,
    input  wire logic        evt_a_capture_event_i,
    input  wire logic        evt_rtc_i,
    input  wire logic        evt_b_timeout_i,
    input  wire logic        evt_b_capture_match_i,
    input  wire logic        evt_b_capture_event_i,
    // counter load interface
    input  wire logic [31:0] timer_a_value_i,
    input  wire logic [15:0] timer_b_value_i,
    output logic             load_a_o,
    output logic             load_b_o,
    output logic [15:0]      load_a_val_o,
    output logic [15:0]      load_b_val_o,
    output logic             mode_32bit_o,
    // interrupt
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        gtm_pkg::gtm_bus_st_t  bus;
        gtm_pkg::gtm_word_t    rdata;
        logic [`GTM_CFG_W-1:0] cfg;
        gtm_pkg::gtm_word_t    mask;
        logic                  load_a;
        logic                  load_b;
    } gtm_state_t;

    gtm_state_t s_q;
    gtm_state_t s_d;

    logic               req;
    logic               wr;
    logic               wr_icr;
    logic               wr_tailr;
    logic               wr_tbilr;
    logic               wr_lo;
    logic               wr_hi;
    logic               is32;
    gtm_pkg::gtm_word_t evt_vec;
    gtm_pkg::gtm_word_t clr_vec;
    gtm_pkg::gtm_word_t raw_vec;
    gtm_pkg::gtm_word_t mis_vec;
    gtm_pkg::gtm_word_t wmask;
    gtm_pkg::gtm_half_t lo_val;
    gtm_pkg::gtm_half_t hi_val;
    gtm_pkg::gtm_half_t hi_rst;
    gtm_pkg::gtm_half_t a_wdata;
    gtm_pkg::gtm_half_t b_wdata;
    gtm_pkg::gtm_word_t rd_word;
    logic               raw_a_timeout;
    logic               raw_a_capture_match;
    logic               raw_a_capture_event;
    logic               raw_rtc;
    logic               raw_b_timeout;
    logic               raw_b_capture_match;
    logic               raw_b_capture_event;

    ////////////////////////////////////////////////////////////////////////
    // decode

    assign req      = wb_cyc_i && wb_stb_i && (s_q.bus == gtm_pkg::GTM_BUS_IDLE);
    assign wr       = req && wb_we_i;
    assign wr_icr   = wr && (wb_adr_i == `GTM_OFF_ICR);
    assign wr_tailr = wr && (wb_adr_i == `GTM_OFF_TAILR);
    assign wr_tbilr = wr && (wb_adr_i == `GTM_OFF_TBILR);
    assign is32     = (s_q.cfg < `GTM_CFG_16BIT);
    assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    ////////////////////////////////////////////////////////////////////////
    // interrupt status

    always_comb begin
        evt_vec = `GTM_WORD_ZERO;
        evt_vec[`GTM_BIT_A_TO] = evt_a_timeout_i;
        evt_vec[`GTM_BIT_A_CM] = evt_a_capture_match_i;
        evt_vec[`GTM_BIT_A_CE] = evt_a_capture_event_i;
        evt_vec[`GTM_BIT_RTC]  = evt_rtc_i;
        evt_vec[`GTM_BIT_B_TO] = evt_b_timeout_i;
        evt_vec[`GTM_BIT_B_CM] = evt_b_capture_match_i;
        evt_vec[`GTM_BIT_B_CE] = evt_b_capture_event_i;
    end

    // only the seven event positions accept a clear
    assign clr_vec = wr_icr ? (wb_dat_i & wmask & `GTM_EVT_MASK) : `GTM_WORD_ZERO;

    // a same-cycle event beats a clear inside each bit cell
    // timer a time-out
    gtm_sticky_bit u_a_timeout (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_A_TO]),
        .clr_i (clr_vec[`GTM_BIT_A_TO]),
        .raw_o (raw_a_timeout)
    );

    // timer a capture match
    gtm_sticky_bit u_a_capture_match (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_A_CM]),
        .clr_i (clr_vec[`GTM_BIT_A_CM]),
        .raw_o (raw_a_capture_match)
    );

    // timer a capture event
    gtm_sticky_bit u_a_capture_event (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_A_CE]),
        .clr_i (clr_vec[`GTM_BIT_A_CE]),
        .raw_o (raw_a_capture_event)
    );

    // real-time-clock event
    gtm_sticky_bit u_rtc_event (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_RTC]),
        .clr_i (clr_vec[`GTM_BIT_RTC]),
        .raw_o (raw_rtc)
    );

    // timer b time-out
    gtm_sticky_bit u_b_timeout (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_B_TO]),
        .clr_i (clr_vec[`GTM_BIT_B_TO]),
        .raw_o (raw_b_timeout)
    );

    // timer b capture match
    gtm_sticky_bit u_b_capture_match (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_B_CM]),
        .clr_i (clr_vec[`GTM_BIT_B_CM]),
        .raw_o (raw_b_capture_match)
    );

    // timer b capture event
    gtm_sticky_bit u_b_capture_event (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (evt_vec[`GTM_BIT_B_CE]),
        .clr_i (clr_vec[`GTM_BIT_B_CE]),
        .raw_o (raw_b_capture_event)
    );

    // only the event positions carry status; reserved positions read zero
    always_comb begin
        raw_vec = `GTM_WORD_ZERO;
        raw_vec[`GTM_BIT_A_TO] = raw_a_timeout;
        raw_vec[`GTM_BIT_A_CM] = raw_a_capture_match;
        raw_vec[`GTM_BIT_A_CE] = raw_a_capture_event;
        raw_vec[`GTM_BIT_RTC]  = raw_rtc;
        raw_vec[`GTM_BIT_B_TO] = raw_b_timeout;
        raw_vec[`GTM_BIT_B_CM] = raw_b_capture_match;
        raw_vec[`GTM_BIT_B_CE] = raw_b_capture_event;
    end

    // masked status is the raw bit gated by its enable
    assign mis_vec = raw_vec & s_q.mask;
    assign irq_o   = |mis_vec;

    ////////////////////////////////////////////////////////////////////////
    // interval load halves

    assign wr_lo   = wr_tailr && wb_sel_i[0] && wb_sel_i[1];
    assign a_wdata = wb_dat_i[`GTM_HALF_W-1:0];

    gtm_load_reg u_lo (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .rst_val_i (`GTM_HALF_ONES),
        .we_i      (wr_lo),
        .wdata_i   (a_wdata),
        .val_o     (lo_val)
    );

    // upper half is the b load value: from tailr in 32-bit, own offset in 16-bit
    assign wr_hi   = (wr_tailr && is32 && wb_sel_i[2] && wb_sel_i[3]) ||
                     (wr_tbilr && !is32 && wb_sel_i[0] && wb_sel_i[1]);
    assign b_wdata = wr_tailr ? wb_dat_i[31:`GTM_HALF_W] : wb_dat_i[`GTM_HALF_W-1:0];
    // reset value follows the mode that reset itself selects, not the live cfg,
    // which is stale or unknown on the first reset edge
    assign hi_rst  = (`GTM_CFG_RESET < `GTM_CFG_16BIT) ? `GTM_HALF_ONES : `GTM_HALF_ZERO;

    gtm_load_reg u_hi (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .rst_val_i (hi_rst),
        .we_i      (wr_hi),
        .wdata_i   (b_wdata),
        .val_o     (hi_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data, latched into the answer register on the request edge

    always_comb begin
        rd_word = `GTM_WORD_ZERO;
        case (wb_adr_i)
            `GTM_OFF_CFG: begin
                rd_word = {29'h0, s_q.cfg};
            end
            `GTM_OFF_IMR: begin
                rd_word = s_q.mask;
            end
            `GTM_OFF_RIS: begin
                rd_word = raw_vec;
            end
            `GTM_OFF_MIS: begin
                rd_word = mis_vec;
            end
            `GTM_OFF_ICR: begin
                rd_word = `GTM_WORD_ZERO;
            end
            `GTM_OFF_TAILR: begin
                if (is32) begin
                    rd_word = {hi_val, lo_val};
                end else begin
                    rd_word = {`GTM_HALF_ZERO, lo_val};
                end
            end
            `GTM_OFF_TBILR: begin
                // in 32-bit mode this offset shows the live b count
                if (is32) begin
                    rd_word = {`GTM_HALF_ZERO, timer_b_value_i};
                end else begin
                    rd_word = {`GTM_HALF_ZERO, hi_val};
                end
            end
            `GTM_OFF_TAVAL: begin
                rd_word = timer_a_value_i;
            end
            `GTM_OFF_TBVAL: begin
                rd_word = {`GTM_HALF_ZERO, timer_b_value_i};
            end
            default: begin
                rd_word = `GTM_WORD_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus and config

    always_comb begin
        s_d        = s_q;
        s_d.load_a = 1'b0;
        s_d.load_b = 1'b0;
        case (s_q.bus)
            gtm_pkg::GTM_BUS_IDLE: begin
                if (req) begin
                    s_d.bus   = gtm_pkg::GTM_BUS_ACK;
                    s_d.rdata = `GTM_WORD_ZERO;
                    if (wb_we_i) begin
                        case (wb_adr_i)
                            `GTM_OFF_CFG: begin
                                if (wb_sel_i[0]) begin
                                    s_d.cfg = wb_dat_i[`GTM_CFG_W-1:0];
                                end
                            end
                            `GTM_OFF_IMR: begin
                                s_d.mask = (s_q.mask & ~wmask) |
                                           (wb_dat_i & wmask & `GTM_EVT_MASK);
                            end
                            default: begin
                            end
                        endcase
                        s_d.load_a = wr_lo;
                        s_d.load_b = wr_hi;
                    end else begin
                        s_d.rdata = rd_word;
                    end
                end
            end
            gtm_pkg::GTM_BUS_ACK: begin
                s_d.bus = gtm_pkg::GTM_BUS_IDLE;
            end
            default: begin
                s_d.bus = gtm_pkg::GTM_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.bus    <= gtm_pkg::GTM_BUS_IDLE;
            s_q.rdata  <= `GTM_WORD_ZERO;
            s_q.cfg    <= `GTM_CFG_RESET;
            s_q.mask   <= `GTM_WORD_ZERO;
            s_q.load_a <= 1'b0;
            s_q.load_b <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_ack_o     = (s_q.bus == gtm_pkg::GTM_BUS_ACK);
    assign wb_dat_o     = s_q.rdata;
    assign load_a_o     = s_q.load_a;
    assign load_b_o     = s_q.load_b;
    assign load_a_val_o = lo_val;
    assign load_b_val_o = hi_val;
    assign mode_32bit_o = is32;

endmodule : gtm_timer_irq_load

/* File: verif/gtm_asserts.sv */
/* port checker for the timer interrupt and load block.
   assumes the defines header on the include path and one clock. */
`include "gtm_defs.svh"
`timescale 1ns/1ps
module gtm_asserts (
    // bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // events
    input wire logic        evt_a_timeout_i,
    input wire logic        evt_a_capture_match_i,
    input wire logic        evt_a_capture_event_i,
    input wire logic        evt_rtc_i,
    input wire logic        evt_b_timeout_i,
    input wire logic        evt_b_capture_match_i,
    input wire logic        evt_b_capture_event_i,
    // load and interrupt
    input wire logic        load_a_o,
    input wire logic        load_b_o,
    input wire logic [15:0] load_a_val_o,
    input wire logic [15:0] load_b_val_o,
    input wire logic        mode_32bit_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic wr;
    logic rd;
    logic evt;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign evt = evt_a_timeout_i || evt_a_capture_match_i || evt_a_capture_event_i
        || evt_rtc_i || evt_b_timeout_i || evt_b_capture_match_i || evt_b_capture_event_i;
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_irq_rise; $rose(irq_o) |-> $past(evt || wr); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall; $fell(irq_o) |-> $past(wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_load_a;
        wr && wb_adr_i == `GTM_OFF_TAILR && wb_sel_i[1:0] == 2'h3 |=> load_a_o;
    endproperty
    a_load_a: assert property (p_load_a) else $error("no counter a load");
    property p_load_a_src; load_a_o |-> $past(wr && wb_adr_i == `GTM_OFF_TAILR); endproperty
    a_load_a_src: assert property (p_load_a_src) else $error("stray a load");
    property p_load_b_src;
        load_b_o |-> $past(wr && wb_adr_i == (mode_32bit_o ? `GTM_OFF_TAILR : `GTM_OFF_TBILR));
    endproperty
    a_load_b_src: assert property (p_load_b_src) else $error("stray b load");
    property p_hi_zero;
        rd && wb_adr_i == `GTM_OFF_TAILR && !mode_32bit_o |=> wb_dat_o[31:16] == 16'h0000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper half not zero");
    property p_rd_load;
        rd && wb_adr_i == `GTM_OFF_TAILR && mode_32bit_o
            |=> wb_dat_o == {$past(load_b_val_o), $past(load_a_val_o)};
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("load read wrong");
    property p_icr_zero; rd && wb_adr_i == `GTM_OFF_ICR |=> wb_dat_o == 32'h00000000; endproperty
    a_icr_zero: assert property (p_icr_zero) else $error("clear reg not zero");
    c_irq: cover property ($rose(irq_o));
    c_load_b: cover property (load_b_o);
    c_mode16: cover property (rd && !mode_32bit_o);
endmodule : gtm_asserts

bind gtm_timer_irq_load gtm_asserts i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .evt_a_timeout_i(evt_a_timeout_i),
    .evt_a_capture_match_i(evt_a_capture_match_i), .evt_rtc_i(evt_rtc_i),
    .evt_a_capture_event_i(evt_a_capture_event_i), .evt_b_timeout_i(evt_b_timeout_i),
    .evt_b_capture_match_i(evt_b_capture_match_i), .load_a_o(load_a_o), .load_b_o(load_b_o),
    .evt_b_capture_event_i(evt_b_capture_event_i), .load_a_val_o(load_a_val_o),
    .load_b_val_o(load_b_val_o), .mode_32bit_o(mode_32bit_o), .irq_o(irq_o));

/* File: verif/tb_top.sv */
/* self-checking bench for the timer interrupt and load block.
   assumes the design and checker are compiled first. */
`include "gtm_defs.svh"
`timescale 1ns/1ps
module tb_top;
    logic        clk_i, rst_i, cyc, stb, we, ack, la, lb, m32o, irq, m32;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [6:0]  ev;
    logic [15:0] tbv, lav, lbv, m_lo, m_hi;
    logic [31:0] wdat, dout, rd, tav, seed, m_ris, m_ien;
    int          n_errors, compares, cycles;
    gtm_timer_irq_load i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .evt_a_timeout_i(ev[0]), .evt_a_capture_match_i(ev[1]), .evt_a_capture_event_i(ev[2]),
        .evt_rtc_i(ev[3]), .evt_b_timeout_i(ev[4]), .evt_b_capture_match_i(ev[5]),
        .evt_b_capture_event_i(ev[6]), .timer_a_value_i(tav), .timer_b_value_i(tbv),
        .load_a_o(la), .load_b_o(lb), .load_a_val_o(lav), .load_b_val_o(lbv),
        .mode_32bit_o(m32o), .irq_o(irq));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic conclude();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1);
        chk("ack wait", 32'h2, 32'(k));
        rd = dout;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 4'hF, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        bus(1'b1, a, s, d);
        if (a == `GTM_OFF_ICR) m_ris &= ~d;
        if (a == `GTM_OFF_IMR) m_ien = d & `GTM_EVT_MASK;
        if (a == `GTM_OFF_TAILR && s[1:0] == 2'h3) m_lo = d[15:0];
        if (a == `GTM_OFF_TAILR && s[3:2] == 2'h3 && m32) m_hi = d[31:16];
        if (a == `GTM_OFF_TBILR && s[1:0] == 2'h3 && !m32) m_hi = d[15:0];
        if (a == `GTM_OFF_CFG && s[0]) m32 = d[2:0] < 3'h4;
    endtask : wr
    task automatic fire(input logic [6:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 7'h00;
        m_ris |= {21'h0, e[6:4], 4'h0, e[3:0]};
    endtask : fire
    task automatic ck_irq();
        #1;
        chk("irq", {31'h0, |(m_ris & m_ien)}, {31'h0, irq});
    endtask : ck_irq
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            n_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, adr, sel, wdat, ev, tav, tbv} = '0;
        {m_ris, m_ien, n_errors, compares, cycles} = '0;
        {m_lo, m_hi, m32, seed} = {32'hFFFFFFFF, 1'b1, 32'h8};
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("load", `GTM_OFF_TAILR, 32'hFFFFFFFF);
        rdchk("raw", `GTM_OFF_RIS, 32'h0);
        rdchk("unmapped", 8'h80, 32'h0);
        for (int i = 0; i < 40; i++) begin
            if (i % 8 == 0) wr(`GTM_OFF_IMR, 4'hF, rnd());
            fire(7'(rnd()));
            ck_irq();
            wr(`GTM_OFF_ICR, 4'hF, rnd());
            ck_irq();
            rdchk("raw", `GTM_OFF_RIS, m_ris);
            rdchk("masked", `GTM_OFF_MIS, m_ris & m_ien);
            rdchk("clear", `GTM_OFF_ICR, 32'h0);
        end
        for (int i = 0; i < 12; i++) begin
            {tav, tbv} <= {rnd(), 16'(rnd())};
            if (i == 5) wr(`GTM_OFF_CFG, 4'h1, 32'h4);
            if (i == 10) wr(`GTM_OFF_CFG, 4'h1, 32'h1);
            wr(`GTM_OFF_TAILR, (i % 3 == 2) ? 4'h3 : 4'hF, rnd());
            if (i % 2 == 1) wr(`GTM_OFF_TBILR, 4'h3, rnd());
            rdchk("load", `GTM_OFF_TAILR, m32 ? {m_hi, m_lo} : {16'h0, m_lo});
            chk("b load", {16'h0, m_hi}, {16'h0, lbv});
            rdchk("b view", `GTM_OFF_TBILR, {16'h0, m32 ? tbv : m_hi});
            rdchk("a count", `GTM_OFF_TAVAL, tav);
            chk("a load", {16'h0, m_lo}, {16'h0, lav});
            chk("mode", {31'h0, m32}, {31'h0, m32o});
        end
        conclude();
    end
endmodule : tb_top
